// [timer_main_counter_consts.vh]
// Register map, field positions and reset values of the main timer counter
`ifndef TIMER_MAIN_COUNTER_CONSTS_VH
`define TIMER_MAIN_COUNTER_CONSTS_VH

`define ADDR_COUNTER_HIGH   8'h00
`define ADDR_COUNTER_LOW    8'h04
`define ADDR_MODULO_HIGH    8'h08
`define ADDR_MODULO_LOW     8'h0C
`define ADDR_STATUS_CTRL    8'h10
`define ADDR_IRQ_STATUS     8'h14
`define ADDR_IRQ_MASK       8'h18

`define BIT_OVERFLOW_FLAG   7
`define BIT_OVERFLOW_IE     6
`define BIT_CENTER_ALIGN    5

`define BIT_EVT_OVERFLOW    0
`define BIT_EVT_CENTER      1
`define EVT_WIDTH           2

`define RST_COUNTER         16'h0000
`define RST_MODULO          16'h0000
`define RST_BYTE            8'h00
`define COUNT_ALL_ONES      16'hFFFF

`endif

// [count_snapshot.v]
// Holding buffer for coherent two-byte counter reads
module count_snapshot #(
    parameter WIDTH = 16
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             ce,
    input  wire [WIDTH-1:0] liveCount,
    input  wire             readHigh,
    input  wire             readLow,
    input  wire             clearBuf,
    output reg  [WIDTH-1:0] heldCount_q,
    output reg              pending_q
);

    reg highDone_q;
    reg lowDone_q;

    ////////////////////////////////////////////////////////////////////////////
    // Capture on first byte read, release when both read or on clear
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            heldCount_q <= {WIDTH{1'b0}};
            pending_q   <= 1'b0;
            highDone_q  <= 1'b0;
            lowDone_q   <= 1'b0;
        end else if (ce) begin
            if (clearBuf) begin
                pending_q  <= 1'b0;
                highDone_q <= 1'b0;
                lowDone_q  <= 1'b0;
            end else if (!pending_q) begin
                if (readHigh || readLow) begin
                    heldCount_q <= liveCount;
                    pending_q   <= 1'b1;
                    highDone_q  <= readHigh;
                    lowDone_q   <= readLow;
                end
            end else begin
                if ((highDone_q || readHigh) && (lowDone_q || readLow)) begin
                    pending_q  <= 1'b0;
                    highDone_q <= 1'b0;
                    lowDone_q  <= 1'b0;
                end else begin
                    highDone_q <= highDone_q | readHigh;
                    lowDone_q  <= lowDone_q | readLow;
                end
            end
        end
    end

endmodule // count_snapshot

// [timer_main_counter.v]
// Main 16-bit timer counter with modulo, centre-aligned mode and Wishbone registers
//
// How it works
// - One 16-bit counter: free-running, modulo, or up/down in centre-aligned mode.
// - Modulo bytes set terminal value; 0x0000 or 0xFFFF means free running.
// - Counter reads allowed anytime and never disturb counting.
// - Writing either counter byte clears the counter; written data ignored.
// - Centre-aligned: count up 0 to modulo, down to 0, repeat.
// - In up/down, zero and terminal each last one timer clock.
// - Interrupt request is level: overflow flag and its enable both one.
// - Free-running up: wrap 0xFFFF to 0x0000 sets overflow flag.
// - Modulo up: wrap from modulo to zero sets overflow flag.
// - Up/down: flag set turning from modulo to next lower value.
// - Reading either counter byte captures both; other byte returns captured count.
// - Counter keeps counting; buffer holds until both captured bytes read.
// - Counter-clearing write also releases the read buffer.
// - Centre-align select at one picks up/down; at zero normal up counting.
//
// Added by the designer: the register addresses and the Wishbone register port.
`include "timer_main_counter_consts.vh"
module timer_main_counter #(
    parameter WIDTH = 16
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    output reg         overflowIrq,
    output reg         irq
);

    reg  [WIDTH-1:0] count_q;
    reg  [WIDTH-1:0] count_d;
    reg  [WIDTH-1:0] modulo_q;
    reg              countDown_q;
    reg              countDown_d;
    reg              overflowFlag_q;
    reg              flagSeen_q;
    reg              overflowIe_q;
    reg              centerAlign_q;
    reg  [`EVT_WIDTH-1:0] evtStatus_q;
    reg  [`EVT_WIDTH-1:0] evtMask_q;
    reg              wrapEvt;
    reg              centerEvt;

    wire [WIDTH-1:0] heldCount;
    wire             snapPending;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire busWr    = busReq & wb_we_i & wb_sel_i[0];
    wire busRd    = busReq & ~wb_we_i;

    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `ADDR_COUNTER_HIGH) || (a == `ADDR_COUNTER_LOW) ||
                     (a == `ADDR_MODULO_HIGH)  || (a == `ADDR_MODULO_LOW)  ||
                     (a == `ADDR_STATUS_CTRL)  || (a == `ADDR_IRQ_STATUS)  ||
                     (a == `ADDR_IRQ_MASK);
        end
    endfunction

    function hit;
        input [7:0] a;
        input [7:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    wire cntWrite = busWr & (hit(wb_adr_i, `ADDR_COUNTER_HIGH) | hit(wb_adr_i, `ADDR_COUNTER_LOW));
    wire rdHigh   = busRd & hit(wb_adr_i, `ADDR_COUNTER_HIGH);
    wire rdLow    = busRd & hit(wb_adr_i, `ADDR_COUNTER_LOW);
    wire rdCtrl   = busRd & hit(wb_adr_i, `ADDR_STATUS_CTRL);
    wire wrCtrl   = busWr & hit(wb_adr_i, `ADDR_STATUS_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    // Next count
    wire freeRun  = (modulo_q == `RST_MODULO) || (modulo_q == `COUNT_ALL_ONES);
    wire [WIDTH-1:0] termVal = freeRun ? `COUNT_ALL_ONES : modulo_q;

    always @* begin
        count_d     = count_q;
        countDown_d = countDown_q;
        wrapEvt     = 1'b0;
        centerEvt   = 1'b0;
        if (centerAlign_q) begin
            if (!countDown_q) begin
                if (count_q >= termVal) begin
                    count_d     = count_q - 1'b1;
                    countDown_d = 1'b1;
                    wrapEvt     = 1'b1;
                end else begin
                    count_d = count_q + 1'b1;
                end
            end else begin
                if (count_q == `RST_COUNTER) begin
                    count_d     = count_q + 1'b1;
                    countDown_d = 1'b0;
                end else begin
                    count_d = count_q - 1'b1;
                    if (count_q == {{(WIDTH-1){1'b0}}, 1'b1})
                        centerEvt = 1'b1;
                end
            end
        end else begin
            countDown_d = 1'b0;
            if (count_q >= termVal) begin
                count_d = `RST_COUNTER;
                wrapEvt = 1'b1;
            end else begin
                count_d = count_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter and control state
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q        <= `RST_COUNTER;
            countDown_q    <= 1'b0;
            modulo_q       <= `RST_MODULO;
            overflowFlag_q <= 1'b0;
            flagSeen_q     <= 1'b0;
            overflowIe_q   <= 1'b0;
            centerAlign_q  <= 1'b0;
            evtStatus_q    <= {`EVT_WIDTH{1'b0}};
            evtMask_q      <= {`EVT_WIDTH{1'b0}};
        end else if (ce) begin
            if (cntWrite) begin
                count_q     <= `RST_COUNTER;
                countDown_q <= 1'b0;
            end else begin
                count_q     <= count_d;
                countDown_q <= countDown_d;
            end
            if (busWr && hit(wb_adr_i, `ADDR_MODULO_HIGH))
                modulo_q[15:8] <= wb_dat_i[7:0];
            if (busWr && hit(wb_adr_i, `ADDR_MODULO_LOW))
                modulo_q[7:0] <= wb_dat_i[7:0];
            if (rdCtrl && overflowFlag_q)
                flagSeen_q <= 1'b1;
            if (wrapEvt && !cntWrite) begin
                overflowFlag_q <= 1'b1;
            end else if (wrCtrl && flagSeen_q && !wb_dat_i[`BIT_OVERFLOW_FLAG]) begin
                overflowFlag_q <= 1'b0;
                flagSeen_q     <= 1'b0;
            end
            if (wrCtrl) begin
                overflowIe_q  <= wb_dat_i[`BIT_OVERFLOW_IE];
                centerAlign_q <= wb_dat_i[`BIT_CENTER_ALIGN];
            end
            if (busWr && hit(wb_adr_i, `ADDR_IRQ_MASK))
                evtMask_q <= wb_dat_i[`EVT_WIDTH-1:0];
            evtStatus_q <= (evtStatus_q &
                            ~((busWr && hit(wb_adr_i, `ADDR_IRQ_STATUS)) ? wb_dat_i[`EVT_WIDTH-1:0]
                                                                         : {`EVT_WIDTH{1'b0}}))
                           | {centerEvt & ~cntWrite, wrapEvt & ~cntWrite};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read coherency buffer
    count_snapshot #(
        .WIDTH       (WIDTH)
    ) u_snapshot (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .liveCount   (count_q),
        .readHigh    (rdHigh),
        .readLow     (rdLow),
        .clearBuf    (cntWrite),
        .heldCount_q (heldCount),
        .pending_q   (snapPending)
    );

    wire [WIDTH-1:0] readCount = snapPending ? heldCount : count_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer and interrupt outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_dat_o    <= 32'h00000000;
            wb_ack_o    <= 1'b0;
            wb_err_o    <= 1'b0;
            overflowIrq <= 1'b0;
            irq         <= 1'b0;
        end else if (ce) begin
            wb_ack_o <= busReq & mapped(wb_adr_i);
            wb_err_o <= busReq & ~mapped(wb_adr_i);
            wb_dat_o <= 32'h00000000;
            if (busRd) begin
                case (wb_adr_i)
                    `ADDR_COUNTER_HIGH: wb_dat_o[7:0] <= readCount[15:8];
                    `ADDR_COUNTER_LOW:  wb_dat_o[7:0] <= readCount[7:0];
                    `ADDR_MODULO_HIGH:  wb_dat_o[7:0] <= modulo_q[15:8];
                    `ADDR_MODULO_LOW:   wb_dat_o[7:0] <= modulo_q[7:0];
                    `ADDR_STATUS_CTRL: begin
                        wb_dat_o[`BIT_OVERFLOW_FLAG] <= overflowFlag_q;
                        wb_dat_o[`BIT_OVERFLOW_IE]   <= overflowIe_q;
                        wb_dat_o[`BIT_CENTER_ALIGN]  <= centerAlign_q;
                    end
                    `ADDR_IRQ_STATUS:   wb_dat_o[`EVT_WIDTH-1:0] <= evtStatus_q;
                    `ADDR_IRQ_MASK:     wb_dat_o[`EVT_WIDTH-1:0] <= evtMask_q;
                    default:            wb_dat_o <= 32'h00000000;
                endcase
            end
            overflowIrq <= overflowFlag_q & overflowIe_q;
            irq         <= |(evtStatus_q & evtMask_q);
        end
    end

endmodule // timer_main_counter

// [timer_main_counter_chk.sv]
// Assertions on the bus and interrupt ports of the main timer counter
`include "timer_main_counter_consts.vh"
module timer_main_counter_chk #(
    parameter WIDTH = 16
) (
    input logic        clk,
    input logic        rst,
    input logic        ce,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [7:0]  wb_adr_i,
    input logic [3:0]  wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    input logic        wb_err_o,
    input logic        overflowIrq,
    input logic        irq
);
    logic mapped, reqMap, reqUnmap, ctrlWr, irqWr;
    assign mapped   = wb_adr_i[1:0] == 2'h0 && wb_adr_i <= `ADDR_IRQ_MASK;
    assign reqMap   = wb_cyc_i && wb_stb_i && ce && mapped;
    assign reqUnmap = wb_cyc_i && wb_stb_i && ce && !mapped;
    assign ctrlWr   = wb_ack_o && wb_we_i && wb_adr_i == `ADDR_STATUS_CTRL;
    assign irqWr    = wb_ack_o && wb_we_i && (wb_adr_i == `ADDR_IRQ_STATUS || wb_adr_i == `ADDR_IRQ_MASK);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(reqMap)) else $error("ack without mapped request");
    chk_err_cause: assert property (wb_err_o |-> $past(reqUnmap)) else $error("err without unmapped request");
    chk_resp_excl: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err together");
    chk_ack_bound: assert property (reqMap && !wb_ack_o && !wb_err_o |=> wb_ack_o) else $error("ack late");
    chk_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
    chk_ovf_fall: assert property ($fell(overflowIrq) |-> ctrlWr || $past(ctrlWr))
        else $error("overflow request fell without control write");
    chk_irq_fall: assert property ($fell(irq) |-> irqWr || $past(irqWr))
        else $error("irq fell without status or mask write");
endmodule // timer_main_counter_chk
////////////////////////////////////////////////////////////////////////////////
bind timer_main_counter timer_main_counter_chk #(.WIDTH(WIDTH)) i_timer_main_counter_chk (
    .clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .overflowIrq(overflowIrq), .irq(irq));

// [timer_main_counter_tb.sv]
// Self-checking bench for the main timer counter
`include "timer_main_counter_consts.vh"
module timer_main_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, ce, cyc, stb, we, ack, err, ovfIrq, irq, errSeen;
    logic [7:0]  adr, rd, v1;
    logic [3:0]  sel;
    logic [31:0] datW, datR;
    int          fail_count, total_checks, cycles;
    timer_main_counter #(.WIDTH(16)) i_timer_main_counter (
        .clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .wb_err_o(err),
        .overflowIrq(ovfIrq), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (n >= 20) chk(8'h00, 8'h01);
        rd = datR[7:0];
        errSeen = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic lvl(input logic [1:0] exp);
        @(negedge clk);
        chk({6'h0, ovfIrq, irq}, {6'h0, exp});
        @(posedge clk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            fail_count++;
            test_done;
        end
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        datW = 32'h00000000;
        cycles = 0;
        fail_count = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(0, `ADDR_STATUS_CTRL, 0); chk(rd, 8'h00);
        wb(0, `ADDR_MODULO_LOW, 0); chk(rd, 8'h00);
        wb(0, `ADDR_IRQ_MASK, 0); chk(rd, 8'h00);
        wb(0, 8'h1C, 0); chk({7'h0, errSeen}, 8'h01);
        $display("reset values test done");
        wb(1, `ADDR_COUNTER_LOW, 8'hA5); wb(0, `ADDR_COUNTER_LOW, 0); v1 = rd;
        repeat (300) @(posedge clk);
        wb(0, `ADDR_COUNTER_HIGH, 0); chk(rd, 8'h00);
        wb(0, `ADDR_COUNTER_LOW, 0); chk({7'h0, rd != v1}, 8'h01);
        wb(0, `ADDR_COUNTER_HIGH, 0); chk(rd, 8'h01);
        wb(0, `ADDR_COUNTER_LOW, 0); v1 = rd; wb(1, `ADDR_COUNTER_HIGH, 8'h5A);
        repeat (300) @(posedge clk);
        wb(0, `ADDR_COUNTER_LOW, 0); chk({7'h0, rd != v1}, 8'h01);
        wb(0, `ADDR_COUNTER_HIGH, 0); chk(rd, 8'h01);
        $display("coherent read test done");
        wb(1, `ADDR_MODULO_LOW, 8'h10); wb(1, `ADDR_STATUS_CTRL, 8'h40); wb(1, `ADDR_COUNTER_LOW, 0);
        for (int i = 0; i < 20; i++) begin
            wb(0, `ADDR_COUNTER_HIGH, 0); chk(rd, 8'h00);
            wb(0, `ADDR_COUNTER_LOW, 0); chk({7'h0, rd <= 8'h10}, 8'h01);
        end
        wb(0, `ADDR_STATUS_CTRL, 0); chk(rd, 8'hC0);
        wb(0, `ADDR_IRQ_STATUS, 0); chk(rd, 8'h01);
        lvl(2'b10);
        $display("modulo test done");
        wb(1, `ADDR_MODULO_LOW, 0); wb(1, `ADDR_COUNTER_LOW, 0); wb(1, `ADDR_STATUS_CTRL, 8'h40);
        wb(1, `ADDR_IRQ_STATUS, 8'h03); wb(0, `ADDR_STATUS_CTRL, 0); chk(rd, 8'h40);
        lvl(2'b00);
        repeat (65600) @(posedge clk);
        wb(0, `ADDR_STATUS_CTRL, 0); chk(rd, 8'hC0);
        wb(0, `ADDR_COUNTER_HIGH, 0); chk(rd, 8'h00);
        wb(0, `ADDR_COUNTER_LOW, 0); lvl(2'b10);
        wb(1, `ADDR_IRQ_MASK, 8'h01); lvl(2'b11);
        wb(1, `ADDR_IRQ_STATUS, 8'h01); lvl(2'b10);
        $display("free run and interrupt test done");
        wb(1, `ADDR_MODULO_LOW, 8'h08); wb(1, `ADDR_STATUS_CTRL, 8'h60); wb(1, `ADDR_COUNTER_LOW, 0);
        wb(1, `ADDR_IRQ_STATUS, 8'h03);
        repeat (40) @(posedge clk);
        wb(0, `ADDR_IRQ_STATUS, 0); chk(rd, 8'h03);
        wb(0, `ADDR_STATUS_CTRL, 0); chk(rd, 8'hE0);
        for (int i = 0; i < 10; i++) begin
            wb(0, `ADDR_COUNTER_HIGH, 0); chk(rd, 8'h00);
            wb(0, `ADDR_COUNTER_LOW, 0); chk({7'h0, rd <= 8'h08}, 8'h01);
        end
        $display("centre-aligned test done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(0, `ADDR_STATUS_CTRL, 0); chk(rd, 8'h00);
        $display("second reset test done");
        test_done;
    end
endmodule // timer_main_counter_tb
